// file: rtl/vmf_pkg.sv
// constants for the voltage monitor fault reaction block
// Operation
// - io overvoltage impact: 1x asserts reset, default 1x
// - io undervoltage impact: 1x asserts reset, default 01
// - aux overvoltage impact: 1x asserts reset, default 1x
// - aux undervoltage impact: 1x asserts reset, default 01
// - aux functions fault only when otp-enabled
// - aux overvoltage switches off assigned regulator while the fault lasts
// - external regulator: nothing off, flag still set
// - overvoltage debounce selectable 25 or 45 us
// - undervoltage debounce selectable 5/15/25/40 us
// - overvoltage threshold code, +4.5 to +12 percent
// - undervoltage threshold code, -4.5 to -12 percent
// - monitoring runs only while failsafe enable high
package vmf_pkg;
   // clock and debounce timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int OV_SHORT_NS   = 25000;
   localparam int OV_LONG_NS    = 45000;
   localparam int UV_T0_NS      = 5000;
   localparam int UV_T1_NS      = 15000;
   localparam int UV_T2_NS      = 25000;
   localparam int UV_T3_NS      = 40000;
   localparam int CNT_W         = 11;
   typedef logic [CNT_W-1:0] vmf_cnt_t;
   // least times, rounded up to whole cycles
   localparam vmf_cnt_t OV_SHORT_CYC = CNT_W'((OV_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam vmf_cnt_t OV_LONG_CYC  = CNT_W'((OV_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam vmf_cnt_t UV_T0_CYC    = CNT_W'((UV_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam vmf_cnt_t UV_T1_CYC    = CNT_W'((UV_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam vmf_cnt_t UV_T2_CYC    = CNT_W'((UV_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam vmf_cnt_t UV_T3_CYC    = CNT_W'((UV_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // monitor channel order
   localparam int NUM_MON = 4;
   localparam int CH_IO_OV  = 0;
   localparam int CH_IO_UV  = 1;
   localparam int CH_AUX_OV = 2;
   localparam int CH_AUX_UV = 3;
   // threshold code: 0 is 4.5 percent, 0.5 percent per step, 15 is 12 percent
   localparam logic [7:0] THR_CODE_MAX = 8'h0F;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_IMPACT = 8'h04;
   localparam logic [7:0] OFS_ASSIGN = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MASK   = 8'h10;
   localparam logic [7:0] OFS_LIVE   = 8'h14;
   // impact field layout, two bits per channel in channel order
   localparam logic [7:0] IMPACT_RST = 8'h66;
   // regulator assignment codes
   localparam logic [1:0] ASG_EXTERNAL = 2'h0;
   localparam logic [1:0] ASG_PRE      = 2'h1;
   localparam logic [1:0] ASG_LINEAR   = 2'h2;
   localparam logic [1:0] ASG_THIRD    = 2'h3;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// file: rtl/vmf_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module vmf_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;   // first stage, read only by second
   logic [WIDTH-1:0] sync_reg;   // second stage
   // both stages clear on reset
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end
   assign sync_out = sync_reg;
endmodule

// file: rtl/vmf_debounce.sv
// persistence filter turning a comparator level into a declared fault
`timescale 1ns/1ps
module vmf_debounce import vmf_pkg::*; (
   input  wire logic     clock_in,
   input  wire logic     rst_b_in,
   input  wire logic     enable_in,   // channel active
   input  wire logic     raw_in,      // synchronised comparator
   input  wire vmf_cnt_t limit_in,    // debounce length in cycles
   output logic          fault_out    // filtered fault level
);
   vmf_cnt_t cnt_reg, cnt_next;       // cycles the excursion has lasted
   logic     fault_reg, fault_next;
   // next-state: count while raw stays high, drop at once when it falls
   always_comb begin
      cnt_next   = cnt_reg;
      fault_next = fault_reg;
      if (!enable_in || !raw_in) begin
         // short excursion or disabled channel leaves nothing behind
         cnt_next   = '0;
         fault_next = 1'b0;
      end else if (!fault_reg) begin
         if (cnt_reg >= limit_in - 1'b1) begin
            fault_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end
   // registers only
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_reg   <= '0;
         fault_reg <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         fault_reg <= fault_next;
      end
   end
   assign fault_out = fault_reg;

   a_fault_after_limit: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      $rose(fault_reg) |-> ($past(cnt_reg) == $past(limit_in) - 1'b1) && $past(raw_in))
      else $error("fault declared before the debounce time");
   a_fault_drops_raw: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (!raw_in || !enable_in) |=> !fault_reg)
      else $error("fault held after the excursion ended");
endmodule

// file: rtl/vmf_voltage_monitor.sv
// io and aux supply monitor fault reaction with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module vmf_voltage_monitor import vmf_pkg::*; (
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   // axi4-lite slave
   input  wire logic [7:0] s_axi_awaddr_in,
   input  wire logic       s_axi_awvalid_in,
   output logic            s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0] s_axi_wstrb_in,
   input  wire logic       s_axi_wvalid_in,
   output logic            s_axi_wready_out,
   output logic [1:0]      s_axi_bresp_out,
   output logic            s_axi_bvalid_out,
   input  wire logic       s_axi_bready_in,
   input  wire logic [7:0] s_axi_araddr_in,
   input  wire logic       s_axi_arvalid_in,
   output logic            s_axi_arready_out,
   output logic [31:0]     s_axi_rdata_out,
   output logic [1:0]      s_axi_rresp_out,
   output logic            s_axi_rvalid_out,
   input  wire logic       s_axi_rready_in,
   // comparator and enable pins
   input  wire logic       io_ov_cmp_in,
   input  wire logic       io_uv_cmp_in,
   input  wire logic       aux_ov_cmp_in,
   input  wire logic       aux_uv_cmp_in,
   input  wire logic       failsafe_enable_in,
   // one-time-programmable settings
   input  wire logic       aux_ov_enable_in,
   input  wire logic       aux_uv_enable_in,
   input  wire logic       io_ov_debounce_sel_in,
   input  wire logic [1:0] io_uv_debounce_sel_in,
   input  wire logic       aux_ov_debounce_sel_in,
   input  wire logic [1:0] aux_uv_debounce_sel_in,
   input  wire logic [7:0] io_ov_threshold_code_in,
   input  wire logic [7:0] io_uv_threshold_code_in,
   input  wire logic [7:0] aux_ov_threshold_code_in,
   input  wire logic [7:0] aux_uv_threshold_code_in,
   // outputs
   output logic [7:0]      io_ov_threshold_code_out,
   output logic [7:0]      io_uv_threshold_code_out,
   output logic [7:0]      aux_ov_threshold_code_out,
   output logic [7:0]      aux_uv_threshold_code_out,
   output logic            reset_out_pin_out,
   output logic            reset_out_pin_oe_out,
   output logic [2:0]      regulator_off_out,
   output logic            irq_out
);
   localparam int SYNC_W = 45;

   // synchronised pins
   logic [SYNC_W-1:0]  sync_raw, sync_s;
   logic [NUM_MON-1:0] cmp_s;           // comparator levels
   logic               fs_en_s;          // failsafe enable
   logic               aux_ov_en_s;      // aux overvoltage otp enable
   logic               aux_uv_en_s;      // aux undervoltage otp enable
   logic               io_ov_sel_s;      // io overvoltage debounce select
   logic [1:0]         io_uv_sel_s;      // io undervoltage debounce select
   logic               aux_ov_sel_s;     // aux overvoltage debounce select
   logic [1:0]         aux_uv_sel_s;     // aux undervoltage debounce select
   logic [31:0]        thr_s;            // threshold codes, four bytes

   assign sync_raw = {aux_uv_threshold_code_in, aux_ov_threshold_code_in,
                      io_uv_threshold_code_in, io_ov_threshold_code_in,
                      aux_uv_debounce_sel_in, aux_ov_debounce_sel_in,
                      io_uv_debounce_sel_in, io_ov_debounce_sel_in,
                      aux_uv_enable_in, aux_ov_enable_in, failsafe_enable_in,
                      aux_uv_cmp_in, aux_ov_cmp_in, io_uv_cmp_in, io_ov_cmp_in};

   // every pin passes two flip-flops
   vmf_sync #(.WIDTH(SYNC_W)) u_sync (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .async_in (sync_raw),
      .sync_out (sync_s)
   );

   assign {thr_s, aux_uv_sel_s, aux_ov_sel_s, io_uv_sel_s, io_ov_sel_s,
           aux_uv_en_s, aux_ov_en_s, fs_en_s, cmp_s} = sync_s;

   // undervoltage debounce table
   function automatic vmf_cnt_t uv_limit(input logic [1:0] sel);
      vmf_cnt_t cyc;
      case (sel)
         2'h0:    cyc = UV_T0_CYC;
         2'h1:    cyc = UV_T1_CYC;
         2'h2:    cyc = UV_T2_CYC;
         default: cyc = UV_T3_CYC;
      endcase
      return cyc;
   endfunction

   // threshold code clamp to the valid step range
   function automatic logic [7:0] thr_clamp(input logic [7:0] code);
      return (code > THR_CODE_MAX) ? THR_CODE_MAX : code;
   endfunction

   vmf_cnt_t           lim [NUM_MON];   // per-channel debounce cycles
   logic [NUM_MON-1:0] ch_en;            // per-channel activity
   logic [NUM_MON-1:0] flt;              // filtered faults

   // debounce selection and channel enables
   always_comb begin
      lim[CH_IO_OV]  = io_ov_sel_s ? OV_LONG_CYC : OV_SHORT_CYC;
      lim[CH_AUX_OV] = aux_ov_sel_s ? OV_LONG_CYC : OV_SHORT_CYC;
      lim[CH_IO_UV]  = uv_limit(io_uv_sel_s);
      lim[CH_AUX_UV] = uv_limit(aux_uv_sel_s);
      ch_en[CH_IO_OV]  = fs_en_s;
      ch_en[CH_IO_UV]  = fs_en_s;
      ch_en[CH_AUX_OV] = fs_en_s & aux_ov_en_s;
      ch_en[CH_AUX_UV] = fs_en_s & aux_uv_en_s;
   end

   // one filter per monitored function
   for (genvar i = 0; i < NUM_MON; i++) begin : g_mon
      vmf_debounce u_flt (
         .clock_in  (clock_in),
         .rst_b_in  (rst_b_in),
         .enable_in (ch_en[i]),
         .raw_in    (cmp_s[i]),
         .limit_in  (lim[i]),
         .fault_out (flt[i])
      );
   end

   // register state
   logic               init_reg, init_next;         // init phase open
   logic [7:0]         impact_reg, impact_next;     // reset impact fields
   logic [1:0]         assign_reg, assign_next;     // regulator assignment
   logic [NUM_MON-1:0] status_reg, status_next;     // sticky flags
   logic [NUM_MON-1:0] mask_reg, mask_next;         // interrupt enables
   logic [NUM_MON-1:0] flt_d_reg;                    // fault edge detect
   logic               rst_oe_reg, rst_oe_next;     // reset pin pull-down
   logic [2:0]         off_reg, off_next;           // regulator off lines
   logic               irq_reg, irq_next;
   logic [31:0]        thr_reg, thr_next;           // clamped codes
   // bus state
   logic               aw_held_reg, aw_held_next;
   logic [7:0]         awaddr_reg, awaddr_next;
   logic               w_held_reg, w_held_next;
   logic [31:0]        wdata_reg, wdata_next;
   logic               wstrb0_reg, wstrb0_next;
   logic               bvalid_reg, bvalid_next;
   logic [1:0]         bresp_reg, bresp_next;
   logic               rvalid_reg, rvalid_next;
   logic [31:0]        rdata_reg, rdata_next;
   logic [1:0]         rresp_reg, rresp_next;
   logic               wr_do;                        // write performed now
   logic [NUM_MON-1:0] clr;                          // write-one-to-clear

   assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready_out  = !w_held_reg && !bvalid_reg;
   assign s_axi_arready_out = !rvalid_reg;

   // next-state for bus and registers
   always_comb begin
      init_next    = init_reg;
      impact_next  = impact_reg;
      assign_next  = assign_reg;
      mask_next    = mask_reg;
      aw_held_next = aw_held_reg;
      awaddr_next  = awaddr_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb0_next  = wstrb0_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rdata_next   = rdata_reg;
      rresp_next   = rresp_reg;
      clr          = '0;
      wr_do        = aw_held_reg && w_held_reg;
      // address and data taken in either order
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata_in;
         wstrb0_next = s_axi_wstrb_in[0];
      end
      // perform write once both halves are held
      if (wr_do) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = RESP_OKAY;
         case (awaddr_reg)
            OFS_CTRL: begin
               // writing one closes the init phase for good
               if (wstrb0_reg && wdata_reg[0]) begin
                  init_next = 1'b0;
               end
            end
            OFS_IMPACT: begin
               if (wstrb0_reg && init_reg) begin
                  impact_next = wdata_reg[7:0];
               end
            end
            OFS_ASSIGN: begin
               if (wstrb0_reg) begin
                  assign_next = wdata_reg[1:0];
               end
            end
            OFS_STATUS: begin
               if (wstrb0_reg) begin
                  clr = wdata_reg[NUM_MON-1:0];
               end
            end
            OFS_MASK: begin
               if (wstrb0_reg) begin
                  mask_next = wdata_reg[NUM_MON-1:0];
               end
            end
            OFS_LIVE: begin
               // read-only, write ignored
            end
            default: begin
               bresp_next = RESP_SLVERR;
            end
         endcase
      end else if (bvalid_reg && s_axi_bready_in) begin
         bvalid_next = 1'b0;
      end
      // read path
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         rdata_next  = '0;
         case (s_axi_araddr_in)
            OFS_CTRL:   rdata_next[0] = init_reg;
            OFS_IMPACT: rdata_next[7:0] = impact_reg;
            OFS_ASSIGN: rdata_next[1:0] = assign_reg;
            OFS_STATUS: rdata_next[NUM_MON-1:0] = status_reg;
            OFS_MASK:   rdata_next[NUM_MON-1:0] = mask_reg;
            OFS_LIVE:   rdata_next[NUM_MON:0] = {rst_oe_reg, flt};
            default:    rresp_next = RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready_in) begin
         rvalid_next = 1'b0;
      end
   end

   // next-state for fault reaction
   always_comb begin
      // flag set for every regulator kind
      status_next = (status_reg & ~clr) | (flt & ~flt_d_reg);
      irq_next    = |(status_next & mask_next);
      rst_oe_next = (flt[CH_IO_OV] & impact_reg[1]) | (flt[CH_IO_UV] & impact_reg[3]) |
                    (flt[CH_AUX_OV] & impact_reg[5]) | (flt[CH_AUX_UV] & impact_reg[7]);
      off_next    = '0;
      case (assign_reg)
         ASG_PRE:    off_next[0] = flt[CH_AUX_OV];
         ASG_LINEAR: off_next[1] = flt[CH_AUX_OV];
         ASG_THIRD:  off_next[2] = flt[CH_AUX_OV];
         default:    off_next = '0;
      endcase
      thr_next    = {thr_clamp(thr_s[31:24]), thr_clamp(thr_s[23:16]),
                     thr_clamp(thr_s[15:8]), thr_clamp(thr_s[7:0])};
   end

   // registers only
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         init_reg    <= 1'b1;
         impact_reg  <= IMPACT_RST;
         assign_reg  <= ASG_EXTERNAL;
         status_reg  <= '0;
         mask_reg    <= '0;
         flt_d_reg   <= '0;
         rst_oe_reg  <= 1'b0;
         off_reg     <= '0;
         irq_reg     <= 1'b0;
         thr_reg     <= '0;
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= '0;
         wstrb0_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end else begin
         init_reg    <= init_next;
         impact_reg  <= impact_next;
         assign_reg  <= assign_next;
         status_reg  <= status_next;
         mask_reg    <= mask_next;
         flt_d_reg   <= flt;
         rst_oe_reg  <= rst_oe_next;
         off_reg     <= off_next;
         irq_reg     <= irq_next;
         thr_reg     <= thr_next;
         aw_held_reg <= aw_held_next;
         awaddr_reg  <= awaddr_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb0_reg  <= wstrb0_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         rvalid_reg  <= rvalid_next;
         rdata_reg   <= rdata_next;
         rresp_reg   <= rresp_next;
      end
   end

   // output drive
   assign s_axi_bvalid_out          = bvalid_reg;
   assign s_axi_bresp_out           = bresp_reg;
   assign s_axi_rvalid_out          = rvalid_reg;
   assign s_axi_rdata_out           = rdata_reg;
   assign s_axi_rresp_out           = rresp_reg;
   assign reset_out_pin_out         = 1'b0;
   assign reset_out_pin_oe_out      = rst_oe_reg;
   assign regulator_off_out         = off_reg;
   assign irq_out                   = irq_reg;
   assign io_ov_threshold_code_out  = thr_reg[7:0];
   assign io_uv_threshold_code_out  = thr_reg[15:8];
   assign aux_ov_threshold_code_out = thr_reg[23:16];
   assign aux_uv_threshold_code_out = thr_reg[31:24];

   a_io_ov_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (flt[CH_IO_OV] && impact_reg[1]) |=> reset_out_pin_oe_out)
      else $error("io overvoltage did not assert reset");
   a_io_uv_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (flt[CH_IO_UV] && impact_reg[3]) |=> reset_out_pin_oe_out)
      else $error("io undervoltage did not assert reset");
   a_aux_ov_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (flt[CH_AUX_OV] && impact_reg[5]) |=> reset_out_pin_oe_out)
      else $error("aux overvoltage did not assert reset");
   a_no_impact_reset: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      ((flt & {impact_reg[7], impact_reg[5], impact_reg[3], impact_reg[1]}) == '0)
      |=> !reset_out_pin_oe_out)
      else $error("reset asserted without a fault configured for it");
   a_aux_disabled: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (!aux_ov_en_s && !flt[CH_AUX_OV]) |=> !flt[CH_AUX_OV])
      else $error("disabled aux function raised a fault");
   a_regulator_off: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (flt[CH_AUX_OV] && assign_reg == ASG_LINEAR) |=> regulator_off_out == 3'h2)
      else $error("assigned regulator not switched off");
   a_external_flag: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      (assign_reg == ASG_EXTERNAL && flt[CH_AUX_OV] && !flt_d_reg[CH_AUX_OV])
      |=> (regulator_off_out == 3'h0) && status_reg[CH_AUX_OV])
      else $error("external rail handling wrong");
   a_impact_locked: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      !init_reg |=> $stable(impact_reg))
      else $error("impact fields changed after init phase");
   a_ov_min_time: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      $rose(flt[CH_IO_OV]) |-> $past(cmp_s[CH_IO_OV], 8))
      else $error("overvoltage declared too early");
   a_thr_range: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      thr_s[7:0] > THR_CODE_MAX |=> io_ov_threshold_code_out == THR_CODE_MAX)
      else $error("threshold code not clamped");
   a_fs_disabled: assert property (@(posedge clock_in) disable iff (!rst_b_in)
      !fs_en_s |=> flt == '0)
      else $error("fault reported while monitoring disabled");
endmodule

// file: dv/vmf_rail_model.sv
// partner model: reset line with pull-up and the three on-chip rails
`timescale 1ns/1ps
module vmf_rail_model (
   input  wire logic       pin_val_in,      // value when the device drives
   input  wire logic       pin_oe_in,       // device pulls the line
   input  wire logic [2:0] reg_off_in,      // shutdown requests
   output logic            mcu_reset_b_out, // reset as the mcu sees it
   output logic [2:0]      rail_on_out      // rails delivering power
);
   // pull-up wins while nobody drives the line
   assign mcu_reset_b_out = pin_oe_in ? pin_val_in : 1'b1;
   // a rail is down while its shutdown is requested
   assign rail_on_out = ~reg_off_in;
endmodule

// file: dv/vmf_voltage_monitor_bench.sv
// self-checking bench for the voltage monitor fault reaction block
`timescale 1ns/1ps
module vmf_voltage_monitor_bench;
   import vmf_pkg::*;
   logic clock_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, irq_out;
   logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, thr, io_ov_threshold_code_out, io_uv_threshold_code_out;
   logic [7:0] aux_ov_threshold_code_out, aux_uv_threshold_code_out;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rrsp, brsp;
   logic [3:0] cmp, mk;
   logic [2:0] regulator_off_out, rail_on;
   logic fs_en, aux_en, reset_out_pin_out, reset_out_pin_oe_out, mcu_rst_b;
   int failures, n_compared;
   vmf_voltage_monitor i_vmf_voltage_monitor (.clock_in, .rst_b_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
      .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
      .io_ov_cmp_in(cmp[0]), .io_uv_cmp_in(cmp[1]), .aux_ov_cmp_in(cmp[2]), .aux_uv_cmp_in(cmp[3]),
      .failsafe_enable_in(fs_en), .aux_ov_enable_in(aux_en), .aux_uv_enable_in(aux_en),
      .io_ov_debounce_sel_in(1'b0), .io_uv_debounce_sel_in(2'h3), .aux_ov_debounce_sel_in(1'b1),
      .aux_uv_debounce_sel_in(2'h0), .io_ov_threshold_code_in(thr), .io_uv_threshold_code_in(thr),
      .aux_ov_threshold_code_in(thr), .aux_uv_threshold_code_in(thr), .io_ov_threshold_code_out,
      .io_uv_threshold_code_out, .aux_ov_threshold_code_out, .aux_uv_threshold_code_out,
      .reset_out_pin_out, .reset_out_pin_oe_out, .regulator_off_out, .irq_out);
   vmf_rail_model i_vmf_rail_model (.pin_val_in(reset_out_pin_out), .pin_oe_in(reset_out_pin_oe_out),
      .reg_off_in(regulator_off_out), .mcu_reset_b_out(mcu_rst_b), .rail_on_out(rail_on));
   always #12.5 clock_in = ~clock_in;
   // compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // axi write: both halves offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      s_axi_awaddr_in <= a; s_axi_wdata_in <= v;
      s_axi_awvalid_in <= 1'b1; s_axi_wvalid_in <= 1'b1; s_axi_bready_in <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (!s_axi_bvalid_out);
      brsp = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   // axi read: data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] a);
      @(posedge clock_in);
      s_axi_araddr_in <= a; s_axi_arvalid_in <= 1'b1; s_axi_rready_in <= 1'b1;
      do begin
         @(posedge clock_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (!s_axi_rvalid_out);
      rdat = s_axi_rdata_out; rrsp = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("register", e, rdat);
   endtask
   // hold one comparator high for n cycles, then check the reaction
   task automatic run(input int ch, input int n, input logic oe_e, input logic [2:0] off_e, input logic [3:0] st_e);
      cmp[ch] <= 1'b1;
      repeat (n) @(posedge clock_in);
      chk("reset_line", !oe_e, mcu_rst_b);
      chk("rails", {~off_e}, rail_on);
      cmp[ch] <= 1'b0;
      repeat (8) @(posedge clock_in);
      chk("rails_back", 3'h7, rail_on);
      chk("irq", |(st_e & mk), irq_out);
      rchk(OFS_STATUS, st_e);
      wr(OFS_STATUS, 32'hF);
      rchk(OFS_STATUS, 32'h0);
   endtask
   task automatic finish_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      #500000;
      failures++;
      finish_test();
   end
   initial begin
      clock_in = 0; rst_b_in = 0; cmp = 0; fs_en = 1; aux_en = 1; thr = 8'h20; mk = 4'hF;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
      s_axi_awaddr_in = 0; s_axi_araddr_in = 0; s_axi_wdata_in = 0; failures = 0; n_compared = 0;
      repeat (16) @(posedge clock_in);
      rst_b_in <= 1'b1;
      rchk(OFS_IMPACT, 32'h66);
      rchk(OFS_CTRL, 32'h1);
      // codes need two sync stages and the output flop after reset
      repeat (2) @(posedge clock_in);
      chk("thr_clamp", THR_CODE_MAX, io_ov_threshold_code_out);
      thr <= 8'h07;
      repeat (6) @(posedge clock_in);
      chk("thr", {4{8'h07}}, {io_ov_threshold_code_out, io_uv_threshold_code_out,
         aux_ov_threshold_code_out, aux_uv_threshold_code_out});
      rd(8'h40);
      chk("resp", RESP_SLVERR, rrsp);
      wr(8'h40, 32'h0);
      chk("bresp", RESP_SLVERR, brsp);
      wr(OFS_MASK, 32'hF);
      chk("bresp_ok", RESP_OKAY, brsp);
      // default impact: io overvoltage pulls the reset line
      run(0, 1006, 1, 3'h0, 4'h1);
      wr(OFS_IMPACT, 32'h68);
      wr(OFS_ASSIGN, {30'h0, ASG_LINEAR});
      wr(OFS_CTRL, 32'h1);
      rchk(OFS_CTRL, 32'h0);
      wr(OFS_IMPACT, 32'h0);
      rchk(OFS_IMPACT, 32'h68);
      run(0, 996, 0, 3'h0, 4'h0);
      run(0, 1006, 0, 3'h0, 4'h1);
      run(1, 1606, 1, 3'h0, 4'h2);
      run(2, 1806, 1, 3'h2, 4'h4);
      mk = 4'h7;
      wr(OFS_MASK, 32'h7);
      run(3, 206, 0, 3'h0, 4'h8);
      wr(OFS_ASSIGN, {30'h0, ASG_EXTERNAL});
      run(2, 1806, 1, 3'h0, 4'h4);
      aux_en <= 1'b0;
      repeat (4) @(posedge clock_in);
      run(2, 1806, 0, 3'h0, 4'h0);
      fs_en <= 1'b0;
      repeat (4) @(posedge clock_in);
      run(1, 1606, 0, 3'h0, 4'h0);
      finish_test();
   end
endmodule
